// ### src/ooprc_ctrl.sv
// Purpose: Serial control, overload protection and status readback for eight outputs
// Assumes: Serial clock at most about 1/4 of clk_sys; all serial pins asynchronous
// Notes:   Analog clamping, slew control and the open-load sink live outside
//
// Contract
// - Control bit 0 turns output on, 1 off
// - Shutdown mode: persistent overcurrent latches and disables output
// - Delay timer restarts on each valid latch edge
// - Overcurrent after elapsed delay switches off immediately
// - Sustained mode: overcurrent only regulates, no shutdown
// - Sustained mode: over-temperature latches and disables output
// - Shutdown delay between 70 and 250 us
// - Shift on falling clock; latch on 8-multiple count
// - Select fall loads status; shifted out on rising
// - Status high when the above_threshold sense input of that output is high
`timescale 1ns/1ps
module ooprc_ctrl #(
  parameter int unsigned SHDN_DLY_CYC = ooprc_pkg::SHDN_DLY_CYC
) (
  // Clock and reset
  input  wire logic                  clk_sys,
  input  wire logic                  nrst,
  // Serial pins, asynchronous
  input  wire ooprc_pkg::ooprc_serial_t serial_in,
  output logic                       sdo,
  output logic                       sdo_oe,
  // Mode select pin, asynchronous
  input  wire logic                  protect_mode_select,
  // Analog sense inputs, asynchronous
  input  wire ooprc_pkg::ooprc_sense_t  sense_in,
  // Output drive (1 = transistor on) and overload latches
  output logic [7:0]                 out_on,
  output logic [7:0]                 overload_latch,
  output logic [7:0]                 ctrl_word
);

  // ****************************************
  // Input synchronisers
  // ****************************************
  localparam int unsigned SYNC_W = 3 + 1 + 24;
  logic [SYNC_W-1:0] sync1_r;
  logic [SYNC_W-1:0] sync2_r;
  always_ff @(posedge clk_sys)
  begin
    if (!nrst)
    begin
      sync1_r <= ooprc_pkg::SYNC_RST;
      sync2_r <= ooprc_pkg::SYNC_RST;
    end
    else
    begin
      sync1_r <= {serial_in, protect_mode_select, sense_in};
      sync2_r <= sync1_r;
    end
  end

  ooprc_pkg::ooprc_serial_t ser_s;
  ooprc_pkg::ooprc_sense_t  sns_s;
  logic                     mode_hi;
  assign ser_s   = sync2_r[27:25];
  assign mode_hi = sync2_r[24];
  assign sns_s   = sync2_r[23:0];

  // ****************************************
  // Edge detection
  // ****************************************
  logic sclk_d_r;
  logic sel_d_r;
  always_ff @(posedge clk_sys)
  begin
    if (!nrst)
    begin
      sclk_d_r <= 1'b0;
      sel_d_r  <= 1'b1;
    end
    else
    begin
      sclk_d_r <= ser_s.sclk;
      sel_d_r  <= ser_s.select_low;
    end
  end

  logic sclk_fall;
  logic sclk_rise;
  logic sel_fall;
  logic sel_rise;
  logic sel_act;
  assign sclk_fall = sclk_d_r & ~ser_s.sclk;
  assign sclk_rise = ~sclk_d_r & ser_s.sclk;
  assign sel_fall  = sel_d_r & ~ser_s.select_low;
  assign sel_rise  = ~sel_d_r & ser_s.select_low;
  assign sel_act   = ~ser_s.select_low;

  // ****************************************
  // Shift registers and bit counter
  // ****************************************
  logic [7:0] rx_sh_r;
  logic [7:0] tx_sh_r;
  logic [2:0] bit_cnt_r;
  logic [7:0] status;
  logic       got_bits_r;
  logic       word_ok;
  // A frame with no clocks at all is not a whole group of eight
  assign word_ok = got_bits_r & (bit_cnt_r == 3'h0);

  always_ff @(posedge clk_sys)
  begin
    if (!nrst)
    begin
      rx_sh_r    <= 8'h00;
      bit_cnt_r  <= 3'h0;
      got_bits_r <= 1'b0;
    end
    else if (sel_fall)
    begin
      bit_cnt_r  <= 3'h0;
      got_bits_r <= 1'b0;
    end
    else if (sel_act && sclk_fall)
    begin
      rx_sh_r    <= {rx_sh_r[6:0], ser_s.sdi};
      bit_cnt_r  <= bit_cnt_r + 3'h1;
      got_bits_r <= 1'b1;
    end
  end

  always_ff @(posedge clk_sys)
  begin
    if (!nrst)
      tx_sh_r <= 8'h00;
    else if (sel_fall)
      tx_sh_r <= status;
    else if (sel_act && sclk_rise)
      tx_sh_r <= {tx_sh_r[6:0], 1'b0};
  end

  always_ff @(posedge clk_sys)
  begin
    if (!nrst)
    begin
      sdo    <= 1'b0;
      sdo_oe <= 1'b0;
    end
    else
    begin
      sdo_oe <= sel_act;
      if (sel_fall)
        sdo <= status[7];
      else if (sel_act && sclk_rise)
        sdo <= tx_sh_r[6];
    end
  end

  // ****************************************
  // Control word latch
  // ****************************************
  logic       load_ok;
  logic [7:0] ctrl_r;
  assign load_ok   = sel_rise & word_ok;
  assign ctrl_word = ctrl_r;

  always_ff @(posedge clk_sys)
  begin
    if (!nrst)
      ctrl_r <= ooprc_pkg::CTRL_RST;
    else if (load_ok)
      ctrl_r <= rx_sh_r;
  end

  // ****************************************
  // Shutdown delay timer
  // ****************************************
  logic [11:0] dly_cnt_r;
  logic        dly_done;
  assign dly_done = (dly_cnt_r >= 12'(SHDN_DLY_CYC));

  always_ff @(posedge clk_sys)
  begin
    if (!nrst)
      dly_cnt_r <= ooprc_pkg::DLY_CNT_W0;
    else if (load_ok)
      dly_cnt_r <= ooprc_pkg::DLY_CNT_W0;
    else if (!dly_done)
      dly_cnt_r <= dly_cnt_r + 12'h001;
  end

  // ****************************************
  // Per-output protection
  // ****************************************
  logic [7:0] trip;
  logic [7:0] latch_r;
  assign overload_latch = latch_r;

  generate
    for (genvar i = 0; i < 8; i++)
    begin : g_out
      assign trip[i] = ~ctrl_r[i] &
                       (mode_hi ? sns_s.over_temp[i]
                                : (sns_s.overcurrent[i] & dly_done));

      always_ff @(posedge clk_sys)
      begin
        if (!nrst)
          latch_r[i] <= 1'b0;
        else if (trip[i] && !load_ok)
          latch_r[i] <= 1'b1;
        else if (load_ok)
          latch_r[i] <= 1'b0;
      end

      always_ff @(posedge clk_sys)
      begin
        if (!nrst)
          out_on[i] <= 1'b0;
        else
          out_on[i] <= ~ctrl_r[i] & ~latch_r[i] & ~trip[i];
      end

      assign status[i] = sns_s.above_threshold[i];
    end
  endgenerate

  // ****************************************
  // Checks
  // ****************************************
  chk_on_follows_ctrl: assert property (@(posedge clk_sys) disable iff (!nrst)
    ctrl_r[0] |=> !out_on[0])
    else $error("output on while its control bit says off");
  chk_word_latch: assert property (@(posedge clk_sys) disable iff (!nrst)
    (sel_rise && !word_ok) |=> ctrl_r == $past(ctrl_r))
    else $error("control word latched on partial count");
  chk_timer_restart: assert property (@(posedge clk_sys) disable iff (!nrst)
    load_ok |=> dly_cnt_r == 12'h000)
    else $error("delay timer not restarted by write");
  chk_no_early_trip: assert property (@(posedge clk_sys) disable iff (!nrst)
    (!mode_hi && !dly_done) |=> (latch_r & ~$past(latch_r)) == 8'h00)
    else $error("overload latched before shutdown delay");
  chk_fast_off: assert property (@(posedge clk_sys) disable iff (!nrst)
    (!mode_hi && dly_done && sns_s.overcurrent[5] && !ctrl_r[5] && !load_ok)
      |-> ##[1:150] !out_on[5])
    else $error("output not switched off quickly after overcurrent");
  chk_regulate_stays: assert property (@(posedge clk_sys) disable iff (!nrst)
    (mode_hi && !sns_s.over_temp[0] && !latch_r[0] && !load_ok) |=> !latch_r[0]
      || $past(mode_hi) == 1'b0)
    else $error("sustained mode latched without over-temperature");
  chk_thermal_trip: assert property (@(posedge clk_sys) disable iff (!nrst)
    (mode_hi && sns_s.over_temp[1] && !ctrl_r[1] && !load_ok) |=> latch_r[1])
    else $error("over-temperature did not set overload latch");
  chk_latch_clear: assert property (@(posedge clk_sys) disable iff (!nrst)
    load_ok |=> !latch_r[0])
    else $error("overload latch not cleared by write");
  chk_status_load: assert property (@(posedge clk_sys) disable iff (!nrst)
    sel_fall |=> tx_sh_r == $past(status) && sdo == $past(status[7]))
    else $error("status not loaded on select fall");
  chk_trip_mode: assert property (@(posedge clk_sys) disable iff (!nrst)
    (!mode_hi && trip[0]) |-> sns_s.overcurrent[0] && dly_done)
    else $error("shutdown trip without elapsed overcurrent");
  chk_status_map: assert property (@(posedge clk_sys) disable iff (!nrst)
    status[0] == sns_s.above_threshold[0])
    else $error("status bit not from threshold compare");

  cov_word_load:   cover property (@(posedge clk_sys) disable iff (!nrst) load_ok);
  cov_shdn_trip:   cover property (@(posedge clk_sys) disable iff (!nrst) !mode_hi && trip[3]);
  cov_therm_trip:  cover property (@(posedge clk_sys) disable iff (!nrst) mode_hi && trip[0]);
  cov_bad_count:   cover property (@(posedge clk_sys) disable iff (!nrst) sel_rise && !word_ok);

endmodule : ooprc_ctrl

// ### src/ooprc_pkg.sv
// Purpose: Shared constants and types for the octal output protection controller
// Assumes: System clock of 10 MHz
// Notes:   Times are kept in their printed unit; cycle counts derive from them
package ooprc_pkg;

  // ****************************************
  // Clock and timing
  // ****************************************
  localparam int unsigned CLK_HZ          = 10_000_000;
  localparam int unsigned NUM_OUTPUTS     = 8;
  localparam int unsigned WORD_BITS       = 8;
  // Overcurrent shutdown delay window, microseconds
  localparam int unsigned SHDN_DLY_MIN_US = 70;
  localparam int unsigned SHDN_DLY_TYP_US = 150;
  localparam int unsigned SHDN_DLY_MAX_US = 250;
  // Immediate shutdown bound once the delay has elapsed, microseconds
  localparam int unsigned FAST_OFF_US     = 15;
  localparam int unsigned SHDN_DLY_CYC    = (SHDN_DLY_TYP_US * (CLK_HZ / 1_000_000));
  localparam int unsigned SHDN_MIN_CYC    = ((SHDN_DLY_MIN_US * CLK_HZ) + 999_999) / 1_000_000;
  localparam int unsigned SHDN_MAX_CYC    = (SHDN_DLY_MAX_US * CLK_HZ) / 1_000_000;
  localparam int unsigned FAST_OFF_CYC    = (FAST_OFF_US * CLK_HZ) / 1_000_000;

  // ****************************************
  // Reset values
  // ****************************************
  // All outputs off after reset (bit value 1 means off)
  localparam logic [7:0]  CTRL_RST        = 8'hFF;
  localparam logic [7:0]  LATCH_RST       = 8'h00;
  localparam logic [11:0] DLY_CNT_W0      = 12'h000;
  // Synchroniser image of idle pins: select_low high, sclk and the rest low,
  // so no false select edge follows reset
  localparam logic [27:0] SYNC_RST        = 28'h400_0000;

  // ****************************************
  // Carriers
  // ****************************************
  typedef struct packed {
    logic sclk;
    logic select_low;
    logic sdi;
  } ooprc_serial_t;

  typedef struct packed {
    logic [7:0] overcurrent;
    logic [7:0] over_temp;
    logic [7:0] above_threshold;
  } ooprc_sense_t;

endpackage : ooprc_pkg

// ### test/ooprc_ctrl_test.sv
// Purpose: Self-checking bench for the output protection controller
// Assumes: Shortened shutdown delay of 20 cycles
// Notes:   Random words from a fixed seed, with fault corner cases
`timescale 1ns/1ps
module ooprc_ctrl_test;
  localparam int unsigned DLY = 20;
  logic                     clk_sys = 1'b0;
  logic                     nrst    = 1'b0;
  logic                     mode    = 1'b0;
  logic [7:0]               oc      = 8'h00;
  logic [7:0]               ot      = 8'h00;
  logic [7:0]               thr     = 8'h00;
  logic [7:0]               rd;
  logic [7:0]               w;
  ooprc_pkg::ooprc_serial_t ser;
  logic                     sdo;
  logic                     sdo_oe;
  logic [7:0]               out_on;
  logic [7:0]               ovl;
  logic [7:0]               cw;
  int                       err_total = 0;
  int                       tests_run = 0;

  always #50 clk_sys = ~clk_sys;

  ooprc_ctrl #(.SHDN_DLY_CYC(DLY)) u_ooprc_ctrl (
    .clk_sys(clk_sys), .nrst(nrst), .serial_in(ser), .sdo(sdo), .sdo_oe(sdo_oe),
    .protect_mode_select(mode), .sense_in({oc, ot, thr}), .out_on(out_on),
    .overload_latch(ovl), .ctrl_word(cw));
  ooprc_host_model u_ooprc_host_model (
    .clk_sys(clk_sys), .serial_out(ser), .sdo(sdo), .sdo_oe(sdo_oe));

  task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
    tests_run++;
    if (got !== exp)
    begin
      err_total++;
      $display("CHECK FAILED t=%0t got %h exp %h", $time, got, exp);
    end
  endtask : chk8

  function automatic logic [7:0] exp_drive(input logic [7:0] word, input logic [7:0] tripped);
    return ~word & ~tripped;
  endfunction : exp_drive

  task automatic wait_off(input int idx, input int lim);
    for (int i = 0; i < lim && out_on[idx] !== 1'b0; i++)
      @(posedge clk_sys);
  endtask : wait_off

  task automatic report_and_stop;
    $display("errors %0d of %0d checks", err_total, tests_run);
    if (err_total == 0 && tests_run > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask : report_and_stop

  initial
  begin
    repeat (60000) @(posedge clk_sys);
    err_total++;
    report_and_stop();
  end

  initial
  begin
    void'($urandom(32'h960a_68f0));
    repeat (3) @(posedge clk_sys);
    nrst <= 1'b1;
    repeat (4) @(posedge clk_sys);
    chk8(cw, 8'hFF);
    chk8(out_on | ovl, 8'h00);
    mode <= 1'b1;
    for (int n = 0; n < 12; n++)
    begin
      w = (n == 0) ? 8'h00 : (n == 1) ? 8'hFF : 8'($urandom());
      thr <= 8'($urandom());
      @(posedge clk_sys);
      u_ooprc_host_model.xfer({8'h00, w}, 8, rd);
      chk8(cw, w);
      chk8(out_on, exp_drive(w, 8'h00));
      chk8(rd, thr);
    end
    u_ooprc_host_model.xfer(16'h0055, 7, rd);
    chk8(cw, w);
    u_ooprc_host_model.xfer(16'hA53C, 16, rd);
    chk8(cw, 8'h3C);
    u_ooprc_host_model.xfer(16'h00C3, 0, rd);
    chk8(cw, 8'h3C);
    chk8({7'h00, sdo_oe}, 8'h00);
    mode <= 1'b0;
    u_ooprc_host_model.xfer(16'h0000, 8, rd);
    oc <= 8'h08;
    repeat (5) @(posedge clk_sys);
    chk8(out_on, 8'hFF);
    wait_off(3, DLY + 8);
    chk8(ovl, 8'h08);
    chk8(out_on, 8'hF7);
    oc <= 8'h28;
    wait_off(5, ooprc_pkg::FAST_OFF_CYC);
    chk8(out_on, exp_drive(8'h00, 8'h28));
    chk8(ovl, 8'h28);
    oc <= 8'h00;
    @(posedge clk_sys);
    u_ooprc_host_model.xfer(16'h0000, 8, rd);
    chk8(ovl, 8'h00);
    chk8(out_on, 8'hFF);
    mode <= 1'b1;
    oc   <= 8'hFF;
    repeat (3 * DLY) @(posedge clk_sys);
    chk8(out_on, 8'hFF);
    ot <= 8'h02;
    wait_off(1, 8);
    chk8(ovl, 8'h02);
    chk8(out_on, 8'hFD);
    report_and_stop();
  end
endmodule : ooprc_ctrl_test

// ### test/ooprc_host_model.sv
// Purpose: Serial master model that writes control words and reads status
// Assumes: Link clock of 800 ns made from clk_sys, idle low between frames
// Notes:   Released data line shows the inverse of its last bit
`timescale 1ns/1ps
module ooprc_host_model (
  // Clock
  input  wire logic                     clk_sys,
  // Serial pins
  output ooprc_pkg::ooprc_serial_t      serial_out,
  input  wire logic                     sdo,
  input  wire logic                     sdo_oe
);
  initial serial_out = 3'b010;

  task automatic xfer(input logic [15:0] wr, input int nbits, output logic [7:0] rd);
    rd = 8'h00;
    serial_out.select_low <= 1'b0;
    repeat (8) @(posedge clk_sys);
    for (int i = nbits - 1; i >= 0; i--)
    begin
      // Sample before the rise that moves the next status bit out
      rd = {rd[6:0], sdo & sdo_oe};
      serial_out.sdi  <= wr[i];
      serial_out.sclk <= 1'b1;
      repeat (4) @(posedge clk_sys);
      serial_out.sclk <= 1'b0;
      repeat (4) @(posedge clk_sys);
    end
    serial_out.select_low <= 1'b1;
    serial_out.sdi        <= ~serial_out.sdi;
    repeat (8) @(posedge clk_sys);
  endtask : xfer
endmodule : ooprc_host_model
